/* core/axis_map.sv */
`timescale 1ns/100ps
// maps an output index on one axis to a source coordinate: mirror, then skip, then crop
module axis_map #(
    parameter int CW = 13,
    parameter int FW = 4
) (
    // frame settings of this axis
    input wire logic [FW-1:0] skip_factor,
    input wire logic [FW-1:0] combine_factor,
    input wire logic mirror,
    input wire logic [CW-1:0] roi_start,
    input wire logic [CW-1:0] array_len,
    // output index within the region
    input wire logic [CW-1:0] idx,
    // results
    output logic [CW-1:0] src,
    output logic [CW-1:0] max_len
);
    logic [FW-1:0] step;
    logic [CW+FW-1:0] pos;
    logic skip_on;
    logic comb_on;

    // each reduction only acts while the other is left at one or less
    always_comb begin
        skip_on = (skip_factor > 1) && (combine_factor <= 1);
        comb_on = (combine_factor > 1) && (skip_factor <= 1);
        if (skip_on) begin
            step = skip_factor;
        end else if (comb_on) begin
            step = combine_factor;
        end else begin
            step = FW'(1);
        end
        pos = (CW + FW)'(roi_start + idx) * (CW + FW)'(step);
        if (mirror) begin
            src = CW'(array_len - CW'(1) - CW'(pos));
        end else begin
            src = CW'(pos);
        end
        max_len = CW'(array_len / CW'(step));
    end
endmodule

/* core/image_roi_decimate_flip.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - column skip above one, with column combine at one or less, keeps one pixel out of each group of that many
// - row skip above one, with row combine at one or less, keeps one line out of each group of that many
// - column skip of one keeps every pixel of a line while column combine is at one or less
// - row skip of one keeps every line of the frame while row combine is at one or less
// - combining only acts while the skip factor on that axis is at one or less
// - skipping discards unselected pixels, never averages them
// - column mirroring reverses pixel order before the region crop
// - column mirroring on a color sensor swaps the reported bayer column phase, RG becomes GR
// - row mirroring reverses line order before the region crop
// - row mirroring on a color sensor swaps the reported bayer row phase, RG becomes GB
// - reports a fixed array width of 5496 pixels
// - reports a fixed array height of 3672 pixels
// - maximum output width follows the column reduction, not the region
// - maximum output height follows the row reduction, not the region
// - region starts at a column offset and spans the output width
// - region starts at a row offset and spans the output height
// - a selected synthetic image replaces sensor data as the source
// - combine factor one means none; above one it disables skipping
module image_roi_decimate_flip #(
    parameter int CW = image_fmt_pkg::COORD_W,
    parameter int FW = image_fmt_pkg::FACT_W,
    parameter int PW = image_fmt_pkg::PIX_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // frame settings, taken when a frame starts
    input wire logic [FW-1:0] col_skip_factor,
    input wire logic [FW-1:0] row_skip_factor,
    input wire logic [FW-1:0] col_combine_factor,
    input wire logic [FW-1:0] row_combine_factor,
    input wire logic mirror_columns,
    input wire logic mirror_rows,
    input wire logic [CW-1:0] roi_col_start,
    input wire logic [CW-1:0] roi_row_start,
    input wire logic [CW-1:0] roi_cols,
    input wire logic [CW-1:0] roi_rows,
    input wire logic [1:0] synthetic_image_type,
    input wire logic color_sensor,
    input wire logic [1:0] array_phase,
    // frame control
    input wire logic frame_start,
    output logic busy,
    // sensor readout
    output logic src_rd,
    output logic [CW-1:0] src_col,
    output logic [CW-1:0] src_row,
    input wire logic [PW-1:0] src_data,
    // pixel stream towards the transport
    output logic pix_valid,
    output logic [PW-1:0] pix_data,
    output logic pix_sof,
    output logic pix_eol,
    output logic pix_eof,
    // reported values
    output logic [CW-1:0] array_cols,
    output logic [CW-1:0] array_rows,
    output logic [CW-1:0] max_out_cols,
    output logic [CW-1:0] max_out_rows,
    output logic [1:0] out_phase
);
    // frame settings held for the frame in flight
    logic [FW-1:0] col_skip_reg, col_skip_next;
    logic [FW-1:0] row_skip_reg, row_skip_next;
    logic [FW-1:0] col_comb_reg, col_comb_next;
    logic [FW-1:0] row_comb_reg, row_comb_next;
    logic mir_c_reg, mir_c_next;
    logic mir_r_reg, mir_r_next;
    logic [CW-1:0] col_start_reg, col_start_next;
    logic [CW-1:0] row_start_reg, row_start_next;
    logic [CW-1:0] cols_reg, cols_next;
    logic [CW-1:0] rows_reg, rows_next;
    logic [1:0] pat_reg, pat_next;
    logic color_reg, color_next;
    logic [1:0] phase_in_reg, phase_in_next;

    // scan state
    image_fmt_pkg::scan_state_e state_reg, state_next;
    logic [CW-1:0] x_reg, x_next;
    logic [CW-1:0] y_reg, y_next;

    // request stage and data stage
    logic a_valid_reg, a_valid_next;
    logic a_rd_reg, a_rd_next;
    logic [CW-1:0] a_col_reg, a_col_next;
    logic [CW-1:0] a_row_reg, a_row_next;
    logic [2:0] a_mark_reg, a_mark_next;
    logic a_pat_reg, a_pat_next;
    logic b_valid_reg, b_valid_next;
    logic [2:0] b_mark_reg, b_mark_next;
    logic b_pat_reg, b_pat_next;

    // output and report registers
    logic o_valid_reg, o_valid_next;
    logic [PW-1:0] o_data_reg, o_data_next;
    logic [2:0] o_mark_reg, o_mark_next;
    logic [CW-1:0] max_c_reg, max_c_next;
    logic [CW-1:0] max_r_reg, max_r_next;
    logic [1:0] phase_reg, phase_next;
    logic busy_reg, busy_next;

    logic [CW-1:0] map_col, map_row, lim_col, lim_row;
    logic [PW-1:0] pat_pixel;
    logic last_col, last_row;

    // column and row address mapping
    axis_map #(.CW(CW), .FW(FW)) col_map (
        .skip_factor(col_skip_reg),
        .combine_factor(col_comb_reg),
        .mirror(mir_c_reg),
        .roi_start(col_start_reg),
        .array_len(image_fmt_pkg::ARRAY_COLS),
        .idx(x_reg),
        .src(map_col),
        .max_len(lim_col)
    );

    axis_map #(.CW(CW), .FW(FW)) row_map (
        .skip_factor(row_skip_reg),
        .combine_factor(row_comb_reg),
        .mirror(mir_r_reg),
        .roi_start(row_start_reg),
        .array_len(image_fmt_pkg::ARRAY_ROWS),
        .idx(y_reg),
        .src(map_row),
        .max_len(lim_row)
    );

    // synthetic source, same latency as the sensor
    pattern_gen #(.CW(CW), .PW(PW)) pattern (
        .core_clk(core_clk),
        .rst(rst),
        .synthetic_image_type(pat_reg),
        .col(a_col_reg),
        .row(a_row_reg),
        .pixel(pat_pixel)
    );

    // settings follow the inputs while idle and freeze during a frame
    always_comb begin
        if (state_reg == image_fmt_pkg::ST_IDLE) begin
            col_skip_next = col_skip_factor;
            row_skip_next = row_skip_factor;
            col_comb_next = col_combine_factor;
            row_comb_next = row_combine_factor;
            mir_c_next = mirror_columns;
            mir_r_next = mirror_rows;
            col_start_next = roi_col_start;
            row_start_next = roi_row_start;
            cols_next = roi_cols;
            rows_next = roi_rows;
            pat_next = synthetic_image_type;
            color_next = color_sensor;
            phase_in_next = array_phase;
        end else begin
            col_skip_next = col_skip_reg;
            row_skip_next = row_skip_reg;
            col_comb_next = col_comb_reg;
            row_comb_next = row_comb_reg;
            mir_c_next = mir_c_reg;
            mir_r_next = mir_r_reg;
            col_start_next = col_start_reg;
            row_start_next = row_start_reg;
            cols_next = cols_reg;
            rows_next = rows_reg;
            pat_next = pat_reg;
            color_next = color_reg;
            phase_in_next = phase_in_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            col_skip_reg <= image_fmt_pkg::FACTOR_RST;
            row_skip_reg <= image_fmt_pkg::FACTOR_RST;
            col_comb_reg <= image_fmt_pkg::FACTOR_RST;
            row_comb_reg <= image_fmt_pkg::FACTOR_RST;
            mir_c_reg <= 1'b0;
            mir_r_reg <= 1'b0;
            col_start_reg <= image_fmt_pkg::COORD_RST;
            row_start_reg <= image_fmt_pkg::COORD_RST;
            cols_reg <= image_fmt_pkg::COORD_RST;
            rows_reg <= image_fmt_pkg::COORD_RST;
            pat_reg <= image_fmt_pkg::PAT_OFF;
            color_reg <= 1'b0;
            phase_in_reg <= image_fmt_pkg::PHASE_RG;
        end else begin
            col_skip_reg <= col_skip_next;
            row_skip_reg <= row_skip_next;
            col_comb_reg <= col_comb_next;
            row_comb_reg <= row_comb_next;
            mir_c_reg <= mir_c_next;
            mir_r_reg <= mir_r_next;
            col_start_reg <= col_start_next;
            row_start_reg <= row_start_next;
            cols_reg <= cols_next;
            rows_reg <= rows_next;
            pat_reg <= pat_next;
            color_reg <= color_next;
            phase_in_reg <= phase_in_next;
        end
    end

    // scan of the region, one pixel request per cycle
    always_comb begin
        state_next = state_reg;
        x_next = x_reg;
        y_next = y_reg;
        a_valid_next = 1'b0;
        a_rd_next = 1'b0;
        a_col_next = a_col_reg;
        a_row_next = a_row_reg;
        a_mark_next = 3'h0;
        a_pat_next = 1'b0;
        last_col = (x_reg == cols_reg - CW'(1));
        last_row = (y_reg == rows_reg - CW'(1));
        case (state_reg)
            image_fmt_pkg::ST_IDLE: begin
                x_next = '0;
                y_next = '0;
                if (frame_start && (roi_cols != '0) && (roi_rows != '0)) begin
                    state_next = image_fmt_pkg::ST_SCAN;
                end
            end
            image_fmt_pkg::ST_SCAN: begin
                a_valid_next = 1'b1;
                a_pat_next = (pat_reg != image_fmt_pkg::PAT_OFF);
                a_rd_next = (pat_reg == image_fmt_pkg::PAT_OFF);
                a_col_next = map_col;
                a_row_next = map_row;
                a_mark_next = {last_col && last_row, last_col, (x_reg == '0) && (y_reg == '0)};
                if (last_col) begin
                    x_next = '0;
                    y_next = y_reg + CW'(1);
                    if (last_row) begin
                        state_next = image_fmt_pkg::ST_IDLE;
                    end
                end else begin
                    x_next = x_reg + CW'(1);
                end
            end
            default: begin
                state_next = image_fmt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= image_fmt_pkg::ST_IDLE;
            x_reg <= image_fmt_pkg::COORD_RST;
            y_reg <= image_fmt_pkg::COORD_RST;
            a_valid_reg <= 1'b0;
            a_rd_reg <= 1'b0;
            a_col_reg <= image_fmt_pkg::COORD_RST;
            a_row_reg <= image_fmt_pkg::COORD_RST;
            a_mark_reg <= 3'h0;
            a_pat_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            x_reg <= x_next;
            y_reg <= y_next;
            a_valid_reg <= a_valid_next;
            a_rd_reg <= a_rd_next;
            a_col_reg <= a_col_next;
            a_row_reg <= a_row_next;
            a_mark_reg <= a_mark_next;
            a_pat_reg <= a_pat_next;
        end
    end

    // data stage, output selection and reported values
    always_comb begin
        b_valid_next = a_valid_reg;
        b_mark_next = a_mark_reg;
        b_pat_next = a_pat_reg;
        o_valid_next = b_valid_reg;
        o_mark_next = b_valid_reg ? b_mark_reg : 3'h0;
        o_data_next = o_data_reg;
        if (b_valid_reg) begin
            o_data_next = b_pat_reg ? pat_pixel : src_data;
        end
        max_c_next = lim_col;
        max_r_next = lim_row;
        phase_next = phase_in_reg;
        if (color_reg) begin
            phase_next = phase_in_reg ^ {mir_r_reg, mir_c_reg};
        end
        busy_next = (state_next != image_fmt_pkg::ST_IDLE) || a_valid_next || a_valid_reg
            || b_valid_reg;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            b_valid_reg <= 1'b0;
            b_mark_reg <= 3'h0;
            b_pat_reg <= 1'b0;
            o_valid_reg <= 1'b0;
            o_data_reg <= '0;
            o_mark_reg <= 3'h0;
            max_c_reg <= image_fmt_pkg::ARRAY_COLS;
            max_r_reg <= image_fmt_pkg::ARRAY_ROWS;
            phase_reg <= image_fmt_pkg::PHASE_RG;
            busy_reg <= 1'b0;
        end else begin
            b_valid_reg <= b_valid_next;
            b_mark_reg <= b_mark_next;
            b_pat_reg <= b_pat_next;
            o_valid_reg <= o_valid_next;
            o_data_reg <= o_data_next;
            o_mark_reg <= o_mark_next;
            max_c_reg <= max_c_next;
            max_r_reg <= max_r_next;
            phase_reg <= phase_next;
            busy_reg <= busy_next;
        end
    end

    // fixed array size held in flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            array_cols <= image_fmt_pkg::ARRAY_COLS;
            array_rows <= image_fmt_pkg::ARRAY_ROWS;
        end else begin
            array_cols <= image_fmt_pkg::ARRAY_COLS;
            array_rows <= image_fmt_pkg::ARRAY_ROWS;
        end
    end

    // outputs
    assign busy = busy_reg;
    assign src_rd = a_rd_reg;
    assign src_col = a_col_reg;
    assign src_row = a_row_reg;
    assign pix_valid = o_valid_reg;
    assign pix_data = o_data_reg;
    assign pix_sof = o_mark_reg[0];
    assign pix_eol = o_mark_reg[1];
    assign pix_eof = o_mark_reg[2];
    assign max_out_cols = max_c_reg;
    assign max_out_rows = max_r_reg;
    assign out_phase = phase_reg;
endmodule

/* core/pattern_gen.sv */
`timescale 1ns/100ps
// synthetic pixel source, one cycle behind its coordinates
module pattern_gen #(
    parameter int CW = 13,
    parameter int PW = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // selection and coordinates
    input wire logic [1:0] synthetic_image_type,
    input wire logic [CW-1:0] col,
    input wire logic [CW-1:0] row,
    // generated pixel
    output logic [PW-1:0] pixel
);
    logic [PW-1:0] pixel_reg;
    logic [PW-1:0] pixel_next;

    // pattern value from the coordinates
    always_comb begin
        case (synthetic_image_type)
            image_fmt_pkg::PAT_DIAG: pixel_next = PW'(col) + PW'(row);
            image_fmt_pkg::PAT_COL_RAMP: pixel_next = PW'(col);
            image_fmt_pkg::PAT_CHECKER: begin
                if (col[image_fmt_pkg::CHECK_BIT] ^ row[image_fmt_pkg::CHECK_BIT]) begin
                    pixel_next = '1;
                end else begin
                    pixel_next = '0;
                end
            end
            default: pixel_next = '0;
        endcase
    end

    // register the value
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pixel_reg <= '0;
        end else begin
            pixel_reg <= pixel_next;
        end
    end

    assign pixel = pixel_reg;
endmodule

/* dv/image_roi_decimate_flip_sva.sv */
`timescale 1ns/100ps
// watches frame control, stream markers and reported values
module image_roi_decimate_flip_sva #(
    parameter int CW = 13,
    parameter int FW = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // settings
    input wire logic [FW-1:0] col_skip_factor,
    input wire logic [FW-1:0] row_skip_factor,
    input wire logic [FW-1:0] col_combine_factor,
    input wire logic [FW-1:0] row_combine_factor,
    input wire logic mirror_columns,
    input wire logic mirror_rows,
    input wire logic [CW-1:0] roi_cols,
    input wire logic [CW-1:0] roi_rows,
    input wire logic [1:0] synthetic_image_type,
    input wire logic color_sensor,
    input wire logic [1:0] array_phase,
    // control and stream
    input wire logic frame_start,
    input wire logic busy,
    input wire logic src_rd,
    input wire logic pix_valid,
    input wire logic pix_sof,
    input wire logic pix_eol,
    input wire logic pix_eof,
    // reported values
    input wire logic [CW-1:0] array_cols,
    input wire logic [CW-1:0] array_rows,
    input wire logic [CW-1:0] max_out_cols,
    input wire logic [CW-1:0] max_out_rows,
    input wire logic [1:0] out_phase
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // effective step of one axis
    function automatic logic [FW-1:0] step_of(logic [FW-1:0] sk, logic [FW-1:0] cf);
        if (sk > 1 && cf <= 1) return sk;
        if (cf > 1 && sk <= 1) return cf;
        return 1;
    endfunction

    // idle with the skip, combine, mirror, color and phase settings held
    sequence settle_s;
        !busy && !frame_start && $stable({col_skip_factor, row_skip_factor,
            col_combine_factor, row_combine_factor, mirror_columns, mirror_rows,
            color_sensor, array_phase});
    endsequence
    sequence taken_s;
        frame_start && !busy && roi_cols != 0 && roi_rows != 0;
    endsequence

    AST_ARRAY_COLS: assert property (array_cols == 13'h1578)
        else $error("array width wrong");
    AST_ARRAY_ROWS: assert property (array_rows == 13'h0e58)
        else $error("array height wrong");
    AST_MAX_COLS: assert property (settle_s [*3] |->
        max_out_cols == 13'h1578 / step_of(col_skip_factor, col_combine_factor))
        else $error("max width wrong");
    AST_MAX_ROWS: assert property (settle_s [*3] |->
        max_out_rows == 13'h0e58 / step_of(row_skip_factor, row_combine_factor))
        else $error("max height wrong");
    AST_PHASE: assert property (settle_s [*3] |->
        out_phase == (color_sensor ? array_phase ^ {mirror_rows, mirror_columns} : array_phase))
        else $error("phase wrong");
    AST_START: assert property (taken_s |-> ##1 busy ##3 (pix_valid && pix_sof))
        else $error("frame start timing wrong");
    AST_SENSOR_READ: assert property ((taken_s and synthetic_image_type == 2'h0)
        |-> ##2 src_rd)
        else $error("no sensor read");
    AST_NO_READ: assert property ((taken_s and synthetic_image_type != 2'h0)
        |-> ##1 (!src_rd) [*4])
        else $error("sensor read with pattern");
    AST_PIPE: assert property (src_rd |-> ##2 pix_valid)
        else $error("pixel not two cycles after read");
    AST_MARKS: assert property (pix_sof || pix_eol || pix_eof |-> pix_valid)
        else $error("marker without pixel");
    AST_IDLE: assert property (!busy |-> !src_rd && !pix_valid)
        else $error("activity while idle");
endmodule

bind image_roi_decimate_flip image_roi_decimate_flip_sva #(.CW(CW), .FW(FW)) chk_u (
    .core_clk(core_clk), .rst(rst), .col_skip_factor(col_skip_factor),
    .row_skip_factor(row_skip_factor), .col_combine_factor(col_combine_factor),
    .row_combine_factor(row_combine_factor), .mirror_columns(mirror_columns),
    .mirror_rows(mirror_rows), .roi_cols(roi_cols), .roi_rows(roi_rows),
    .synthetic_image_type(synthetic_image_type), .color_sensor(color_sensor),
    .array_phase(array_phase), .frame_start(frame_start), .busy(busy), .src_rd(src_rd),
    .pix_valid(pix_valid), .pix_sof(pix_sof), .pix_eol(pix_eol), .pix_eof(pix_eof),
    .array_cols(array_cols), .array_rows(array_rows), .max_out_cols(max_out_cols),
    .max_out_rows(max_out_rows), .out_phase(out_phase));

/* dv/image_roi_decimate_flip_tb_top.sv */
`timescale 1ns/100ps
// drives corner and random frames and checks every pixel
module image_roi_decimate_flip_tb_top;
    logic core_clk, rst, frame_start, color_sensor, mirror_columns, mirror_rows;
    logic [3:0] col_skip_factor, row_skip_factor, col_combine_factor, row_combine_factor;
    logic [12:0] roi_col_start, roi_row_start, roi_cols, roi_rows;
    logic [1:0] synthetic_image_type, array_phase, out_phase;
    logic busy, src_rd, pix_valid, pix_sof, pix_eol, pix_eof;
    logic [12:0] src_col, src_row, array_cols, array_rows, max_out_cols, max_out_rows;
    logic [15:0] src_data, pix_data;
    int errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h0000bcf5;

    image_roi_decimate_flip dut_u (.core_clk(core_clk), .rst(rst),
        .col_skip_factor(col_skip_factor), .row_skip_factor(row_skip_factor),
        .col_combine_factor(col_combine_factor), .row_combine_factor(row_combine_factor),
        .mirror_columns(mirror_columns), .mirror_rows(mirror_rows),
        .roi_col_start(roi_col_start), .roi_row_start(roi_row_start), .roi_cols(roi_cols),
        .roi_rows(roi_rows), .synthetic_image_type(synthetic_image_type),
        .color_sensor(color_sensor), .array_phase(array_phase), .frame_start(frame_start),
        .busy(busy), .src_rd(src_rd), .src_col(src_col), .src_row(src_row),
        .src_data(src_data), .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof),
        .pix_eol(pix_eol), .pix_eof(pix_eof), .array_cols(array_cols),
        .array_rows(array_rows), .max_out_cols(max_out_cols), .max_out_rows(max_out_rows),
        .out_phase(out_phase));
    sensor_model sensor_u (.core_clk(core_clk), .src_rd(src_rd), .src_col(src_col),
        .src_row(src_row), .src_data(src_data));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // step of one axis: only one of skip and combine above one acts
    function automatic logic [3:0] step_of(input logic [3:0] sk, input logic [3:0] cb);
        if (sk > 1 && cb <= 1) return sk;
        if (cb > 1 && sk <= 1) return cb;
        return 4'h1;
    endfunction

    // source coordinate of an output index: mirror, skip, crop
    function automatic logic [12:0] map(input logic [12:0] start, idx, len,
                                        input logic [3:0] st, input logic mir);
        logic [12:0] pos;
        pos = (start + idx) * st;
        return mir ? len - 13'h0001 - pos : pos;
    endfunction

    // synthetic pixel expected at a source coordinate
    function automatic logic [15:0] pat_pix(input logic [1:0] p, input logic [12:0] c, r);
        if (p == 2'h1) return 16'(c) + 16'(r);
        if (p == 2'h2) return 16'(c);
        return {16{c[image_fmt_pkg::CHECK_BIT] ^ r[image_fmt_pkg::CHECK_BIT]}};
    endfunction

    // one comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one frame: small region kept inside the array, settings disturbed mid-frame
    task automatic frame(input logic [3:0] csk, rsk, ccb, rcb, input logic [1:0] pat);
        logic [12:0] nc, nr, cs, rs, c, r;
        logic mc, mr;
        int k;
        @(negedge core_clk);
        nc = 13'(rnd() % 4 + 1);
        nr = 13'(rnd() % 3 + 1);
        cs = 13'(rnd() % 8);
        rs = 13'(rnd() % 8);
        mc = rnd() % 2 == 1;
        mr = rnd() % 2 == 1;
        {col_skip_factor, row_skip_factor, col_combine_factor, row_combine_factor} = {csk, rsk, ccb, rcb};
        {roi_col_start, roi_row_start, roi_cols, roi_rows} = {cs, rs, nc, nr};
        {mirror_columns, mirror_rows, synthetic_image_type} = {mc, mr, pat};
        color_sensor = rnd() % 2 == 1;
        array_phase = 2'(rnd());
        repeat (3) @(negedge core_clk);
        chk(16'(max_out_cols), 16'(13'h1578 / step_of(csk, ccb)));
        chk(16'(max_out_rows), 16'(13'h0e58 / step_of(rsk, rcb)));
        chk(16'(out_phase), 16'(color_sensor ? array_phase ^ {mr, mc} : array_phase));
        chk(16'(array_cols), 16'h1578);
        chk(16'(array_rows), 16'h0e58);
        frame_start = 1'b1;
        @(negedge core_clk);
        frame_start = nc * nr > 2;
        {mirror_columns, mirror_rows, col_skip_factor} = {~mc, ~mr, csk + 4'h1};
        roi_col_start = cs + 13'h0001;
        k = 0;
        repeat (int'(nc * nr) + 8) begin
            @(negedge core_clk);
            frame_start = 1'b0;
            if (pix_valid === 1'b1) begin
                c = map(cs, 13'(k % nc), 13'h1578, step_of(csk, ccb), mc);
                r = map(rs, 13'(k / nc), 13'h0e58, step_of(rsk, rcb), mr);
                if (pat == 2'h0)
                    chk(pix_data, {3'h0, c} ^ {r, 3'h0});
                else
                    chk(pix_data, pat_pix(pat, c, r));
                chk(16'({pix_sof, pix_eol, pix_eof}), 16'({k == 0, k % nc == nc - 1, k == nc * nr - 1}));
                k++;
            end
        end
        chk(16'(k), 16'(nc * nr));
        chk(16'(busy), 16'h0000);
        $display("frame done pixels %0d", k);
    endtask

    // hang guard
    initial begin
        repeat (8000) @(posedge core_clk);
        errors++;
        stop_test();
    end

    // reset, corner frames, pattern frames, random frames
    initial begin
        {rst, frame_start, color_sensor, mirror_columns, mirror_rows} = 5'b10000;
        {col_skip_factor, row_skip_factor, col_combine_factor, row_combine_factor} = 16'h1111;
        {roi_col_start, roi_row_start, roi_cols, roi_rows} = {13'h0, 13'h0, 13'h1, 13'h1};
        {synthetic_image_type, array_phase} = 4'h0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        frame(4'h1, 4'h1, 4'h1, 4'h1, 2'h0);
        frame(4'h3, 4'h2, 4'h1, 4'h1, 2'h0);
        frame(4'h1, 4'h1, 4'h2, 4'h3, 2'h0);
        frame(4'h2, 4'h2, 4'h3, 4'h2, 2'h0);
        for (int i = 1; i < 4; i++) begin
            frame(4'h1, 4'h1, 4'h1, 4'h1, 2'(i));
        end
        repeat (12) begin
            frame(4'(rnd() % 6), 4'(rnd() % 6), 4'(rnd() % 3), 4'(rnd() % 3), 2'h0);
        end
        stop_test();
    end
endmodule

/* dv/sensor_model.sv */
`timescale 1ns/100ps
// sensor readout: one pixel value in the cycle after each request
module sensor_model (
    // clock
    input wire logic core_clk,
    // read request
    input wire logic src_rd,
    input wire logic [12:0] src_col,
    input wire logic [12:0] src_row,
    // pixel value
    output logic [15:0] src_data
);
    // between reads the value toggles, so a late sample never matches by chance
    always_ff @(posedge core_clk) begin
        if (src_rd)
            src_data <= {3'h0, src_col} ^ {src_row, 3'h0};
        else
            src_data <= ~src_data;
    end
endmodule

/* pkg/image_fmt_pkg.sv */
package image_fmt_pkg;

    // geometry of the pixel array and datapath widths
    localparam int COORD_W = 13;
    localparam int FACT_W = 4;
    localparam int PIX_W = 16;
    localparam logic [12:0] ARRAY_COLS = 13'h1578;
    localparam logic [12:0] ARRAY_ROWS = 13'h0e58;

    // values after reset of the frame settings
    localparam logic [3:0] FACTOR_RST = 4'h1;
    localparam logic [12:0] COORD_RST = 13'h0000;

    // bayer phase codes: bit 0 is the column phase, bit 1 the row phase
    localparam logic [1:0] PHASE_RG = 2'h0;
    localparam logic [1:0] PHASE_GR = 2'h1;
    localparam logic [1:0] PHASE_GB = 2'h2;
    localparam logic [1:0] PHASE_BG = 2'h3;

    // synthetic image types
    localparam logic [1:0] PAT_OFF = 2'h0;
    localparam logic [1:0] PAT_DIAG = 2'h1;
    localparam logic [1:0] PAT_COL_RAMP = 2'h2;
    localparam logic [1:0] PAT_CHECKER = 2'h3;

    // checker square size is two to this power
    localparam int CHECK_BIT = 3;

    // cycles from a pixel request to its pixel on the output
    localparam int PIPE_CYCLES = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SCAN = 2'b10
    } scan_state_e;

endpackage
